// *** frame_settings_defs.svh ***
`ifndef FRAME_SETTINGS_DEFS_SVH
`define FRAME_SETTINGS_DEFS_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define TYPE_A_FRAMING_SETTINGS_ADDR 8'h05
`define TYPE_B_FRAMING_SETTINGS_ADDR 8'h06
`define FRAMING_STATUS_ADDR 8'h0A
`define SETTINGS_RESET 8'h00

// -----------------------------------------------------------------------------
// Type A field positions
// -----------------------------------------------------------------------------
`define TA_NO_TX_PARITY_BIT 7
`define TA_NO_RX_PARITY_BIT 6
`define TA_TRANSPORT_FRAME_BIT 5
`define TA_PULSE_MSB 4
`define TA_PULSE_LSB 1
`define TA_ANTICOLL_BIT 0

// -----------------------------------------------------------------------------
// Type B field positions
// -----------------------------------------------------------------------------
`define TB_EGT_MSB 7
`define TB_EGT_LSB 5
`define TB_SOF_LOW_BIT 4
`define TB_SOF_HIGH_BIT 3
`define TB_EOF_LOW_BIT 2
`define TB_MIDPOINT_BIT 1
`define TB_RX_OMIT_BIT 0

// -----------------------------------------------------------------------------
// Timing figures in etu and carrier periods
// -----------------------------------------------------------------------------
`define EGT_MAX_ETU 4'h6
`define SOF_LOW_SHORT_ETU 4'hA
`define SOF_LOW_LONG_ETU 4'hB
`define SOF_HIGH_SHORT_ETU 4'h2
`define SOF_HIGH_LONG_ETU 4'h3
`define EOF_LOW_SHORT_ETU 4'hA
`define EOF_LOW_LONG_ETU 4'hB
`define TRANSPORT_START_BYTE 8'hF0
`define PULSE_BASE_128 6'h23
`define PULSE_BASE_32 6'h09
`define PULSE_BASE_16 6'h05

`endif

// *** frame_settings_pkg.sv ***
package frame_settings_pkg;
    typedef enum logic [1:0] {
        rate_fc128,
        rate_fc64,
        rate_fc32,
        rate_fc16
    } bit_rate_t;
endpackage : frame_settings_pkg

// *** frame_timing_model.sv ***
`timescale 1ns/1ps

// -----------------------------------------------------------------------------
// Far-side frame timing consumer
// -----------------------------------------------------------------------------
// A receiving card only sees the whole start-of-frame, so the low and high
// phases are summed here the way a card would measure the preamble.
module frame_timing_model (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [3:0] sof_low_etu_i,
    input wire logic [3:0] sof_high_etu_i,
    output logic [7:0] sof_total_etu_o
);
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sof_total_etu_o <= 8'h00;
        end else begin
            sof_total_etu_o <= {4'h0, sof_low_etu_i} + {4'h0, sof_high_etu_i};
        end
    end
endmodule : frame_timing_model

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "frame_settings_defs.svh"

module tb_top;
    import frame_settings_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, set_def = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, start_b, sof_total;
    logic [1:0] rate = 2'h0;
    logic txp, rxp, rxc, tfi, pwv, acl, mid, eofr, omit, last;
    logic [5:0] pw;
    logic [3:0] egt, sofl, sofh, eofl;
    int n_mismatch = 0, total_checks = 0, cycles = 0;

    always #50 clk = ~clk;

    type_a_b_frame_settings u_dut (.ref_clk_i(clk), .reset_i(rst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .set_default_i(set_def), .bit_rate_i(rate),
        .rdata_o(rdata), .tx_parity_en_o(txp), .rx_parity_check_en_o(rxp),
        .rx_crc_check_en_o(rxc), .transport_frame_insert_o(tfi),
        .transport_start_byte_o(start_b), .pulse_width_o(pw), .pulse_width_valid_o(pwv),
        .anticoll_frame_o(acl), .guard_time_etu_o(egt), .sof_low_etu_o(sofl),
        .sof_high_etu_o(sofh), .eof_low_etu_o(eofl), .midpoint_timing_o(mid),
        .rx_eof_required_o(eofr), .receive_start_stop_omit_o(omit),
        .rx_store_last_byte_only_o(last));

    frame_timing_model u_far (.ref_clk_i(clk), .reset_i(rst), .sof_low_etu_i(sofl),
        .sof_high_etu_i(sofh), .sof_total_etu_o(sof_total));

    // -------------------------------------------------------------------------
    // Bus and compare tasks
    // -------------------------------------------------------------------------
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check8

    // Decoded outputs settle one edge after the write edge.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check8("read data", exp, rdata);
    endtask : reg_read

    task automatic check_b(input logic [3:0] l, input logic [3:0] h, input logic [3:0] e);
        check8("sof low", {4'h0, l}, {4'h0, sofl});
        check8("sof high", {4'h0, h}, {4'h0, sofh});
        check8("eof low", {4'h0, e}, {4'h0, eofl});
    endtask : check_b

    function automatic logic [6:0] pulse_exp(input int r, input int c);
        int s;
        s = (c > 7) ? c - 16 : c;
        if (r == 0) return {1'b1, 6'(35 + s)};
        if (r == 1 && s >= -6 && s <= 3) return {1'b1, 6'(18 + s)};
        if (r == 1 && s >= 4 && s <= 6) return {1'b1, 6'(26 - s)};
        if (r == 2 && s >= -4 && s <= 4) return {1'b1, 6'(9 + s)};
        if (r == 3 && s >= -3 && s <= 3) return {1'b1, 6'(5 + s)};
        return 7'h00;
    endfunction : pulse_exp

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic test_reset_values();
        check8("tx parity", 8'h01, {7'h0, txp});
        check8("rx checks", 8'h03, {6'h0, rxp, rxc});
        check8("pulse width", 8'h23, {2'h0, pw});
        check_b(4'hA, 4'h2, 4'hA);
        reg_read(`TYPE_A_FRAMING_SETTINGS_ADDR, 8'h00);
        reg_read(`TYPE_B_FRAMING_SETTINGS_ADDR, 8'h00);
        reg_read(8'h3C, 8'h00);
        reg_read(`FRAMING_STATUS_ADDR, 8'h63);
        $display("test reset values done");
    endtask : test_reset_values

    task automatic test_type_a_flags();
        reg_write(`TYPE_A_FRAMING_SETTINGS_ADDR, 8'hA1);
        check8("tx parity", 8'h00, {7'h0, txp});
        check8("rx checks", 8'h03, {6'h0, rxp, rxc});
        check8("transport", 8'h01, {7'h0, tfi});
        check8("start byte", 8'hF0, start_b);
        check8("anticoll", 8'h01, {7'h0, acl});
        reg_write(8'h07, 8'hFF);
        reg_read(`TYPE_A_FRAMING_SETTINGS_ADDR, 8'hA1);
        reg_write(`TYPE_A_FRAMING_SETTINGS_ADDR, 8'h40);
        check8("rx checks", 8'h00, {6'h0, rxp, rxc});
        check8("tx parity", 8'h01, {7'h0, txp});
        $display("test type a flags done");
    endtask : test_type_a_flags

    task automatic test_pulse_table();
        logic [6:0] e;
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            rate <= 2'(r);
            for (int c = 0; c < 16; c++) begin
                reg_write(`TYPE_A_FRAMING_SETTINGS_ADDR, 8'(c << 1));
                e = pulse_exp(r, c);
                check8("pulse width", {2'h0, e[5:0]}, {2'h0, pw});
                check8("pulse valid", {7'h0, e[6]}, {7'h0, pwv});
            end
        end
        $display("test pulse table done");
    endtask : test_pulse_table

    task automatic test_type_b();
        for (int g = 0; g < 8; g++) begin
            reg_write(`TYPE_B_FRAMING_SETTINGS_ADDR, 8'(g << 5));
            check8("guard time", (g == 7) ? 8'h06 : 8'(g), {4'h0, egt});
        end
        reg_write(`TYPE_B_FRAMING_SETTINGS_ADDR, 8'h1C);
        check_b(4'hB, 4'h3, 4'hB);
        @(posedge clk);
        #1;
        check8("far sof total", 8'h0E, sof_total);
        reg_write(`TYPE_B_FRAMING_SETTINGS_ADDR, 8'h1E);
        check_b(4'hB, 4'h2, 4'hA);
        check8("midpoint", 8'h01, {7'h0, mid});
        reg_write(`TYPE_B_FRAMING_SETTINGS_ADDR, 8'h1F);
        check_b(4'hA, 4'h2, 4'hA);
        check8("omit flags", 8'h03, {5'h0, eofr, omit, last});
        $display("test type b done");
    endtask : test_type_b

    task automatic test_set_default();
        reg_write(`TYPE_A_FRAMING_SETTINGS_ADDR, 8'hFF);
        @(posedge clk);
        set_def <= 1'b1;
        @(posedge clk);
        set_def <= 1'b0;
        addr <= `TYPE_B_FRAMING_SETTINGS_ADDR;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check8("read after default", 8'h00, rdata);
        reg_read(`TYPE_A_FRAMING_SETTINGS_ADDR, 8'h00);
        reg_read(`TYPE_B_FRAMING_SETTINGS_ADDR, 8'h00);
        $display("test set default done");
    endtask : test_set_default

    // -------------------------------------------------------------------------
    // Run control
    // -------------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // The whole sequence needs about 400 cycles; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        test_reset_values();
        test_type_a_flags();
        test_pulse_table();
        test_type_b();
        test_set_default();
        complete_run();
    end
endmodule : tb_top

// *** type_a_b_frame_settings.sv ***
// Functional notes
// - Transmit parity suppression sends raw FIFO data.
// - Receive suppression stores raw bits, no checks.
// - Transport frame adds F0 and length, strips F0.
// - Pulse width from four-bit field, carrier periods.
// - fc/128 width is 35 plus signed code.
// - Higher rates use fixed pulse width lookup.
// - Both registers reset to zero, also set-default.
// - Extra guard time codes 0..6, 7 gives 6.
// - SOF low 10 or 11 etu.
// - SOF high 2 or 3 etu.
// - EOF low 10 or 11 etu.
// - Midpoint bit overrides SOF and EOF bits.
// - Receive omission: fixed SOF, no EOF, last byte.
`timescale 1ns/1ps
`include "frame_settings_defs.svh"

module type_a_b_frame_settings
    import frame_settings_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic set_default_i,
    input wire logic [1:0] bit_rate_i,
    output logic [7:0] rdata_o,
    output logic tx_parity_en_o,
    output logic rx_parity_check_en_o,
    output logic rx_crc_check_en_o,
    output logic transport_frame_insert_o,
    output logic [7:0] transport_start_byte_o,
    output logic [5:0] pulse_width_o,
    output logic pulse_width_valid_o,
    output logic anticoll_frame_o,
    output logic [3:0] guard_time_etu_o,
    output logic [3:0] sof_low_etu_o,
    output logic [3:0] sof_high_etu_o,
    output logic [3:0] eof_low_etu_o,
    output logic midpoint_timing_o,
    output logic rx_eof_required_o,
    output logic receive_start_stop_omit_o,
    output logic rx_store_last_byte_only_o
);

    // The status register sits at the highest mapped offset and needs four bits.
    if (ADDR_W < 4) begin : g_addr_w_check
        $error("ADDR_W too small for the register map");
    end

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] type_a;
        logic [7:0] type_b;
        logic [7:0] rdata;
        logic tx_par;
        logic rx_par;
        logic rx_crc;
        logic tf;
        logic [5:0] pw;
        logic pw_ok;
        logic antcl;
        logic [3:0] egt;
        logic [3:0] sof_lo;
        logic [3:0] sof_hi;
        logic [3:0] eof_lo;
        logic mid;
        logic eof_req;
        logic omit;
        logic [7:0] sb;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Midpoint timing cannot land on a half etu with integer counts, so the
    // long SOF low, short SOF high and short EOF low values stand in for the
    // centred setting; finer timing would need a sub-etu counter.
    function automatic logic [6:0] pulse_lookup(input logic [3:0] code, input logic [1:0] rate);
        logic signed [5:0] s;
        logic [6:0] r;
        s = {{2{code[3]}}, code};
        r = 7'h00;
        case (bit_rate_t'(rate))
            rate_fc128: r = {1'b1, 6'(`PULSE_BASE_128 + s)};
            rate_fc64: begin
                if (code == 4'h4) r = {1'b1, 6'h16};
                else if (code == 4'h5) r = {1'b1, 6'h15};
                else if (code == 4'h6) r = {1'b1, 6'h14};
                else if (code == 4'h7 || code == 4'h8 || code == 4'h9) r = 7'h00;
                else r = {1'b1, 6'(6'h12 + s)};
            end
            rate_fc32: begin
                if (s >= -6'sh4 && s <= 6'sh4) r = {1'b1, 6'(`PULSE_BASE_32 + s)};
                else r = 7'h00;
            end
            default: begin
                if (s >= -6'sh3 && s <= 6'sh3) r = {1'b1, 6'(`PULSE_BASE_16 + s)};
                else r = 7'h00;
            end
        endcase
        return r;
    endfunction : pulse_lookup

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        logic [6:0] pl;
        logic [2:0] egt_code;
        pl = 7'h00;
        egt_code = 3'h0;
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        if (reset_i || set_default_i) begin
            st_nxt.type_a = `SETTINGS_RESET;
            st_nxt.type_b = `SETTINGS_RESET;
        end else if (wr_i) begin
            if (addr_i == ADDR_W'(`TYPE_A_FRAMING_SETTINGS_ADDR)) st_nxt.type_a = wdata_i;
            if (addr_i == ADDR_W'(`TYPE_B_FRAMING_SETTINGS_ADDR)) st_nxt.type_b = wdata_i;
        end
        if (rd_i) begin
            if (addr_i == ADDR_W'(`TYPE_A_FRAMING_SETTINGS_ADDR)) st_nxt.rdata = st_r.type_a;
            else if (addr_i == ADDR_W'(`TYPE_B_FRAMING_SETTINGS_ADDR)) st_nxt.rdata = st_r.type_b;
            else if (addr_i == ADDR_W'(`FRAMING_STATUS_ADDR)) st_nxt.rdata = {1'b0, st_r.pw_ok, st_r.pw};
        end
        st_nxt.tx_par = ~st_r.type_a[`TA_NO_TX_PARITY_BIT];
        st_nxt.rx_par = ~st_r.type_a[`TA_NO_RX_PARITY_BIT];
        st_nxt.rx_crc = ~st_r.type_a[`TA_NO_RX_PARITY_BIT];
        st_nxt.tf = st_r.type_a[`TA_TRANSPORT_FRAME_BIT];
        // The start byte is constant, yet it is registered like every other output.
        st_nxt.sb = `TRANSPORT_START_BYTE;
        pl = pulse_lookup(st_r.type_a[`TA_PULSE_MSB:`TA_PULSE_LSB], bit_rate_i);
        st_nxt.pw = pl[5:0];
        st_nxt.pw_ok = pl[6];
        st_nxt.antcl = st_r.type_a[`TA_ANTICOLL_BIT];
        egt_code = st_r.type_b[`TB_EGT_MSB:`TB_EGT_LSB];
        st_nxt.egt = (egt_code == 3'h7) ? `EGT_MAX_ETU : {1'b0, egt_code};
        st_nxt.mid = st_r.type_b[`TB_MIDPOINT_BIT];
        st_nxt.omit = st_r.type_b[`TB_RX_OMIT_BIT];
        st_nxt.eof_req = ~st_r.type_b[`TB_RX_OMIT_BIT];
        if (st_r.type_b[`TB_RX_OMIT_BIT]) begin
            st_nxt.sof_lo = `SOF_LOW_SHORT_ETU;
            st_nxt.sof_hi = `SOF_HIGH_SHORT_ETU;
            st_nxt.eof_lo = `EOF_LOW_SHORT_ETU;
        end else if (st_r.type_b[`TB_MIDPOINT_BIT]) begin
            st_nxt.sof_lo = `SOF_LOW_LONG_ETU;
            st_nxt.sof_hi = `SOF_HIGH_SHORT_ETU;
            st_nxt.eof_lo = `EOF_LOW_SHORT_ETU;
        end else begin
            st_nxt.sof_lo = st_r.type_b[`TB_SOF_LOW_BIT] ? `SOF_LOW_LONG_ETU
                                                       : `SOF_LOW_SHORT_ETU;
            st_nxt.sof_hi = st_r.type_b[`TB_SOF_HIGH_BIT] ? `SOF_HIGH_LONG_ETU
                                                        : `SOF_HIGH_SHORT_ETU;
            st_nxt.eof_lo = st_r.type_b[`TB_EOF_LOW_BIT] ? `EOF_LOW_LONG_ETU
                                                       : `EOF_LOW_SHORT_ETU;
        end
        if (reset_i) begin
            st_nxt = '0;
            st_nxt.tx_par = 1'b1;
            st_nxt.rx_par = 1'b1;
            st_nxt.rx_crc = 1'b1;
            st_nxt.eof_req = 1'b1;
            st_nxt.sof_lo = `SOF_LOW_SHORT_ETU;
            st_nxt.sof_hi = `SOF_HIGH_SHORT_ETU;
            st_nxt.eof_lo = `EOF_LOW_SHORT_ETU;
            st_nxt.pw = `PULSE_BASE_128;
            st_nxt.pw_ok = 1'b1;
            st_nxt.sb = `TRANSPORT_START_BYTE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        st_r <= st_nxt;
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign rdata_o = st_r.rdata;
    assign tx_parity_en_o = st_r.tx_par;
    assign rx_parity_check_en_o = st_r.rx_par;
    assign rx_crc_check_en_o = st_r.rx_crc;
    assign transport_frame_insert_o = st_r.tf;
    assign transport_start_byte_o = st_r.sb;
    assign pulse_width_o = st_r.pw;
    assign pulse_width_valid_o = st_r.pw_ok;
    assign anticoll_frame_o = st_r.antcl;
    assign guard_time_etu_o = st_r.egt;
    assign sof_low_etu_o = st_r.sof_lo;
    assign sof_high_etu_o = st_r.sof_hi;
    assign eof_low_etu_o = st_r.eof_lo;
    assign midpoint_timing_o = st_r.mid;
    assign rx_eof_required_o = st_r.eof_req;
    assign receive_start_stop_omit_o = st_r.omit;
    assign rx_store_last_byte_only_o = st_r.omit;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    // A settings write is judged two edges on: the byte lands in its register
    // at the write edge and the decoded outputs follow one edge later.
    sequence wr_a_seq;
        wr_i && !set_default_i && addr_i == ADDR_W'(`TYPE_A_FRAMING_SETTINGS_ADDR);
    endsequence

    sequence wr_b_seq;
        wr_i && !set_default_i && addr_i == ADDR_W'(`TYPE_B_FRAMING_SETTINGS_ADDR);
    endsequence

    sequence default_rd_seq;
        set_default_i ##1 rd_i && addr_i != ADDR_W'(`FRAMING_STATUS_ADDR);
    endsequence

    tx_parity_follow_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_a_seq ##1 !set_default_i |=>
        tx_parity_en_o == !$past(wdata_i[`TA_NO_TX_PARITY_BIT], 2))
        else $error("Transmit parity enable does not follow the written bit.");

    rx_check_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_a_seq ##1 !set_default_i |=>
        rx_parity_check_en_o == !$past(wdata_i[`TA_NO_RX_PARITY_BIT], 2)
        && rx_crc_check_en_o == rx_parity_check_en_o)
        else $error("Receive checks do not follow the written bit.");

    frame_insert_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_a_seq ##1 !set_default_i |=>
        transport_frame_insert_o == $past(wdata_i[`TA_TRANSPORT_FRAME_BIT], 2))
        else $error("Transport frame insert does not follow the written bit.");

    pulse_range_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        bit_rate_i == 2'h0 |=> pulse_width_valid_o
        && pulse_width_o >= 6'h1B && pulse_width_o <= 6'h2A)
        else $error("fc/128 pulse width invalid or out of range.");

    pulse_fc64_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        bit_rate_i == 2'h1 |=> !pulse_width_valid_o
        || (pulse_width_o >= 6'h0C && pulse_width_o <= 6'h16))
        else $error("fc/64 pulse width out of range.");

    pulse_fc32_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        bit_rate_i == 2'h2 |=> !pulse_width_valid_o
        || (pulse_width_o >= 6'h05 && pulse_width_o <= 6'h0D))
        else $error("fc/32 pulse width out of range.");

    pulse_fc16_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        bit_rate_i == 2'h3 |=> !pulse_width_valid_o
        || (pulse_width_o >= 6'h02 && pulse_width_o <= 6'h08))
        else $error("fc/16 pulse width out of range.");

    pulse_invalid_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !pulse_width_valid_o |-> pulse_width_o == 6'h00)
        else $error("Unlisted pulse code gives a nonzero width.");

    default_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        set_default_i |=> ##1 tx_parity_en_o && rx_parity_check_en_o
        && !transport_frame_insert_o && !anticoll_frame_o && guard_time_etu_o == 4'h0
        && rx_eof_required_o && !midpoint_timing_o && !receive_start_stop_omit_o)
        else $error("Settings not cleared by set default.");

    default_read_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        default_rd_seq |=> rdata_o == 8'h00)
        else $error("Read after set default is not zero.");

    guard_follow_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_b_seq ##1 !set_default_i |=> guard_time_etu_o ==
        (($past(wdata_i[`TB_EGT_MSB:`TB_EGT_LSB], 2) == 3'h7) ? `EGT_MAX_ETU
        : {1'b0, $past(wdata_i[`TB_EGT_MSB:`TB_EGT_LSB], 2)}))
        else $error("Guard time does not follow the written code.");

    guard_cap_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        guard_time_etu_o <= `EGT_MAX_ETU)
        else $error("Guard time beyond six etu.");

    sof_follow_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_b_seq ##1 !set_default_i |=> $past(wdata_i[`TB_MIDPOINT_BIT], 2)
        || $past(wdata_i[`TB_RX_OMIT_BIT], 2) || sof_low_etu_o ==
        ($past(wdata_i[`TB_SOF_LOW_BIT], 2) ? `SOF_LOW_LONG_ETU : `SOF_LOW_SHORT_ETU))
        else $error("SOF low length does not follow the written bit.");

    eof_follow_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_b_seq ##1 !set_default_i |=> $past(wdata_i[`TB_MIDPOINT_BIT], 2)
        || $past(wdata_i[`TB_RX_OMIT_BIT], 2) || eof_low_etu_o ==
        ($past(wdata_i[`TB_EOF_LOW_BIT], 2) ? `EOF_LOW_LONG_ETU : `EOF_LOW_SHORT_ETU))
        else $error("EOF low length does not follow the written bit.");

    sof_low_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        sof_low_etu_o == `SOF_LOW_SHORT_ETU || sof_low_etu_o == `SOF_LOW_LONG_ETU)
        else $error("SOF low length out of range.");

    sof_high_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        sof_high_etu_o inside {`SOF_HIGH_SHORT_ETU, `SOF_HIGH_LONG_ETU})
        else $error("SOF high length out of range.");

    eof_low_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        eof_low_etu_o inside {`EOF_LOW_SHORT_ETU, `EOF_LOW_LONG_ETU})
        else $error("EOF low length out of range.");

    midpoint_use_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        midpoint_timing_o && !receive_start_stop_omit_o |->
        sof_low_etu_o == `SOF_LOW_LONG_ETU && sof_high_etu_o == `SOF_HIGH_SHORT_ETU
        && eof_low_etu_o == `EOF_LOW_SHORT_ETU)
        else $error("Midpoint timing not applied.");

    omit_fixed_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        receive_start_stop_omit_o |-> !rx_eof_required_o && rx_store_last_byte_only_o
        && sof_high_etu_o == `SOF_HIGH_SHORT_ETU
        && sof_low_etu_o == `SOF_LOW_SHORT_ETU)
        else $error("Receive omission timing wrong.");

endmodule : type_a_b_frame_settings
